// File: src/bcp_pkg.sv
package bcp_pkg;

  // ----------------------------------------------------------------
  // Decoded protection levels and write targets
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SEC_NONE = 2'h0,
    SEC_STANDARD = 2'h1,
    SEC_ENHANCED = 2'h2,
    SEC_HIGH = 2'h3
  } sec_t;

  typedef enum logic [1:0] {
    SEG_BOOT = 2'h0,
    SEG_GENERAL = 2'h1,
    SEG_CONFIG = 2'h2
  } seg_t;

  // ----------------------------------------------------------------
  // State machines
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OSC_START = 3'h1,
    OSC_FRC = 3'h2,
    OSC_USER = 3'h4
  } osc_state_t;

  typedef enum logic [2:0] {
    KEY_IDLE = 3'h1,
    KEY_HALF = 3'h2,
    KEY_OPEN = 3'h4
  } key_state_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] boot_seg_protect_level;
    logic boot_seg_present_n;
    logic boot_write_guard_n;
    logic [12:0] boot_page_limit;
    logic [1:0] general_seg_protect_level;
    logic user_mem_write_guard_n;
    logic config_write_guard_n;
    logic [2:0] config_seg_protect_level;
    logic swap_instr_disable;
    logic alt_vector_table_disable;
    logic two_speed_startup_enable;
    logic pwm_write_key_lock;
  } nv_cfg_t;

  typedef struct packed {
    logic [11:0] partition_boot_number;
    logic [11:0] partition_boot_number_inverse;
  } boot_seq_t;

  typedef struct packed {
    logic valid;
    seg_t seg;
  } nvm_wr_t;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_STATUS = 12'h000;
  localparam logic [11:0] ADDR_BOOT = 12'h004;
  localparam logic [11:0] ADDR_CTRL = 12'h008;
  localparam logic [11:0] ADDR_KEY = 12'h00C;
  localparam int CTRL_ALT_SEL_BIT = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int ST_BOOT_LVL = 0;
  localparam int ST_GEN_LVL = 2;
  localparam int ST_CFG_LVL = 4;
  localparam int ST_BOOT_EN = 6;
  localparam int ST_BOOT_WR = 7;
  localparam int ST_USER_WR = 8;
  localparam int ST_CFG_WR = 9;
  localparam int ST_SWAP_EN = 10;
  localparam int ST_ALT_VEC = 11;
  localparam int ST_FAST_RC = 12;
  localparam int ST_PWM_LOCK = 13;
  localparam int ST_PWM_OPEN = 14;
  localparam int ST_PART_B = 15;
  localparam int ST_SEQ_A_OK = 16;
  localparam int ST_SEQ_B_OK = 17;
  localparam logic [15:0] PWM_KEY_FIRST = 16'hA5A5;
  localparam logic [15:0] PWM_KEY_SECOND = 16'h5A5A;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Level decoders
  // ----------------------------------------------------------------
  function automatic sec_t sec_decode2(input logic [1:0] f);
    case (f)
      2'h3: sec_decode2 = SEC_NONE;
      2'h2: sec_decode2 = SEC_STANDARD;
      default: sec_decode2 = SEC_HIGH;
    endcase
  endfunction

  function automatic sec_t sec_decode3(input logic [2:0] f);
    case (f)
      3'h7: sec_decode3 = SEC_NONE;
      3'h6: sec_decode3 = SEC_STANDARD;
      3'h5, 3'h4: sec_decode3 = SEC_ENHANCED;
      default: sec_decode3 = SEC_HIGH;
    endcase
  endfunction

endpackage

// File: src/partition_pick.sv
`timescale 1ns/1ns
module partition_pick #(
  parameter int SEQ_W = 12
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Captured sequence numbers
  input wire logic dual_mode,
  input wire logic [SEQ_W-1:0] seq_a,
  input wire logic [SEQ_W-1:0] inv_a,
  input wire logic [SEQ_W-1:0] seq_b,
  input wire logic [SEQ_W-1:0] inv_b,
  // Choice
  output logic part_b_r,
  output logic a_ok_r,
  output logic b_ok_r
);

  if (SEQ_W < 1) begin : g_chk
    $error("partition_pick: SEQ_W must be at least 1.");
  end

  logic a_ok;
  logic b_ok;

  // A number whose stored inverse disagrees is not trusted at all.
  assign a_ok = dual_mode && ((seq_a ^ inv_a) == {SEQ_W{1'b1}});
  assign b_ok = dual_mode && ((seq_b ^ inv_b) == {SEQ_W{1'b1}});

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      part_b_r <= 1'b0;
      a_ok_r <= 1'b0;
      b_ok_r <= 1'b0;
    end else begin
      a_ok_r <= a_ok;
      b_ok_r <= b_ok;
      // Lower number wins; a tie or two bad numbers fall back to A.
      part_b_r <= b_ok && (!a_ok || (seq_b < seq_a));
    end
  end

endmodule // partition_pick

// File: src/boot_code_protect_config.sv
// Local design decisions: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ns
// Operation
// - Boot level: 11 none, 10 standard, 0x high.
// - Presence bit 1 means no boot segment.
// - Boot writes allowed only when guard bit 1.
// - Page limit stored inverted; last page is complement.
// - General level: 11 none, 10 standard, 0x high.
// - User memory writes allowed only when guard 1.
// - Configuration writes allowed only when guard 1.
// - Config level: 111,110,10x,0xx ascending security.
// - Swap instruction ignored while its disable bit 1.
// - Lower valid sequence number selects active partition.
// - Sequence number invalid unless inverse matches complement.
// - Alternate table needs disable 0 and select 1.
// - Alternate table needs an enabled boot segment.
// - Two-speed start runs fast RC until ready.
// - Locked PWM registers need key sequence first.
module boot_code_protect_config #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Nonvolatile configuration
  input wire bcp_pkg::nv_cfg_t nv_cfg,
  input wire bcp_pkg::boot_seq_t seq_a,
  input wire bcp_pkg::boot_seq_t seq_b,
  input wire logic dual_partition_mode,
  // Oscillator start-up
  input wire logic user_osc_ready,
  output bcp_pkg::osc_state_t osc_state_r,
  output logic fast_rc_sel_r,
  // Program memory write checks
  input wire bcp_pkg::nvm_wr_t nvm_wr,
  output logic nvm_wr_grant_r,
  output logic nvm_wr_refuse_r,
  // Swap instruction
  input wire logic swap_instr_req,
  output logic swap_instr_fire_r,
  // PWM register writes
  input wire logic pwm_wr_req,
  output logic pwm_wr_accept_r,
  output logic pwm_wr_reject_r,
  // Decoded protection
  output bcp_pkg::sec_t boot_level_r,
  output bcp_pkg::sec_t general_level_r,
  output bcp_pkg::sec_t config_level_r,
  output logic boot_seg_en_r,
  output logic [12:0] boot_last_page_r,
  output logic boot_wr_allow_r,
  output logic user_wr_allow_r,
  output logic cfg_wr_allow_r,
  output logic swap_instr_en_r,
  output logic alt_vector_en_r,
  output logic part_b_active_r,
  // AXI4-Lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // The register decode compares twelve address bits, so a narrower bus cannot be served.
  if (ADDR_W < 12) begin : g_chk
    $error("boot_code_protect_config: ADDR_W must be at least 12.");
  end

  // ----------------------------------------------------------------
  // Captured configuration
  // ----------------------------------------------------------------
  bcp_pkg::nv_cfg_t cfg_r;
  bcp_pkg::boot_seq_t seq_a_r;
  bcp_pkg::boot_seq_t seq_b_r;
  logic dual_r;
  logic a_ok_r;
  logic b_ok_r;

  // Sampling only while reset is held keeps every decode stable at run time except alt_vector_en_r, which follows the CTRL select bit.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_r <= nv_cfg;
      seq_a_r <= seq_a;
      seq_b_r <= seq_b;
      dual_r <= dual_partition_mode;
    end
  end

  partition_pick #(
    .SEQ_W(12)
  ) u_pick (
    .aclk(aclk),
    .aresetn(aresetn),
    .dual_mode(dual_r),
    .seq_a(seq_a_r.partition_boot_number),
    .inv_a(seq_a_r.partition_boot_number_inverse),
    .seq_b(seq_b_r.partition_boot_number),
    .inv_b(seq_b_r.partition_boot_number_inverse),
    .part_b_r(part_b_active_r),
    .a_ok_r(a_ok_r),
    .b_ok_r(b_ok_r)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic [31:0] ctrl_r;

  // Reset values are the most restrictive reading of every field.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      boot_level_r <= bcp_pkg::SEC_HIGH;
      general_level_r <= bcp_pkg::SEC_HIGH;
      config_level_r <= bcp_pkg::SEC_HIGH;
      boot_seg_en_r <= 1'b0;
      boot_last_page_r <= 13'h0000;
      boot_wr_allow_r <= 1'b0;
      user_wr_allow_r <= 1'b0;
      cfg_wr_allow_r <= 1'b0;
      swap_instr_en_r <= 1'b0;
      alt_vector_en_r <= 1'b0;
    end else begin
      boot_level_r <= bcp_pkg::sec_decode2(cfg_r.boot_seg_protect_level);
      general_level_r <= bcp_pkg::sec_decode2(cfg_r.general_seg_protect_level);
      config_level_r <= bcp_pkg::sec_decode3(cfg_r.config_seg_protect_level);
      boot_seg_en_r <= !cfg_r.boot_seg_present_n;
      boot_last_page_r <= cfg_r.boot_seg_present_n ? 13'h0000 : ~cfg_r.boot_page_limit;
      boot_wr_allow_r <= !cfg_r.boot_seg_present_n && cfg_r.boot_write_guard_n;
      user_wr_allow_r <= cfg_r.user_mem_write_guard_n;
      cfg_wr_allow_r <= cfg_r.config_write_guard_n;
      swap_instr_en_r <= !cfg_r.swap_instr_disable;
      alt_vector_en_r <= !cfg_r.alt_vector_table_disable && ctrl_r[bcp_pkg::CTRL_ALT_SEL_BIT]
                         && !cfg_r.boot_seg_present_n;
    end
  end

  // ----------------------------------------------------------------
  // Write checks and swap instruction
  // ----------------------------------------------------------------
  logic seg_allow;

  always_comb begin
    case (nvm_wr.seg)
      bcp_pkg::SEG_BOOT: seg_allow = boot_wr_allow_r;
      bcp_pkg::SEG_GENERAL: seg_allow = user_wr_allow_r;
      bcp_pkg::SEG_CONFIG: seg_allow = cfg_wr_allow_r;
      default: seg_allow = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nvm_wr_grant_r <= 1'b0;
      nvm_wr_refuse_r <= 1'b0;
      swap_instr_fire_r <= 1'b0;
    end else begin
      nvm_wr_grant_r <= nvm_wr.valid && seg_allow;
      nvm_wr_refuse_r <= nvm_wr.valid && !seg_allow;
      swap_instr_fire_r <= swap_instr_req && swap_instr_en_r;
    end
  end

  // ----------------------------------------------------------------
  // Oscillator start-up
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_state_r <= bcp_pkg::OSC_START;
      fast_rc_sel_r <= 1'b0;
    end else begin
      case (osc_state_r)
        bcp_pkg::OSC_START: begin
          if (cfg_r.two_speed_startup_enable) begin
            osc_state_r <= bcp_pkg::OSC_FRC;
            fast_rc_sel_r <= 1'b1;
          end else begin
            osc_state_r <= bcp_pkg::OSC_USER;
          end
        end
        bcp_pkg::OSC_FRC: begin
          if (user_osc_ready) begin
            osc_state_r <= bcp_pkg::OSC_USER;
            fast_rc_sel_r <= 1'b0;
          end
        end
        bcp_pkg::OSC_USER: fast_rc_sel_r <= 1'b0;
        default: begin
          osc_state_r <= bcp_pkg::OSC_START;
          fast_rc_sel_r <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic aw_have_r;
  logic w_have_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_fire;
  logic key_wr;
  logic [31:0] rdata_nxt;
  logic [1:0] rresp_nxt;
  bcp_pkg::key_state_t key_st_r;

  assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
  assign key_wr = wr_fire && (awaddr_r[11:0] == bcp_pkg::ADDR_KEY) && (wstrb_r[1:0] == 2'h3);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (wr_fire) begin
        aw_have_r <= 1'b0;
      end else if (!aw_have_r && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (wr_fire) begin
        w_have_r <= 1'b0;
      end else if (!w_have_r && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= bcp_pkg::RESP_OKAY;
      ctrl_r <= bcp_pkg::CTRL_RESET;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= bcp_pkg::RESP_OKAY;
      case (awaddr_r[11:0])
        bcp_pkg::ADDR_CTRL: begin
          if (wstrb_r[1]) begin
            ctrl_r[bcp_pkg::CTRL_ALT_SEL_BIT] <= wdata_r[bcp_pkg::CTRL_ALT_SEL_BIT];
          end
        end
        bcp_pkg::ADDR_STATUS, bcp_pkg::ADDR_BOOT, bcp_pkg::ADDR_KEY: ;
        default: s_axi_bresp <= bcp_pkg::RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    rresp_nxt = bcp_pkg::RESP_OKAY;
    case (s_axi_araddr[11:0])
      bcp_pkg::ADDR_STATUS: begin
        rdata_nxt[bcp_pkg::ST_BOOT_LVL +: 2] = boot_level_r;
        rdata_nxt[bcp_pkg::ST_GEN_LVL +: 2] = general_level_r;
        rdata_nxt[bcp_pkg::ST_CFG_LVL +: 2] = config_level_r;
        rdata_nxt[bcp_pkg::ST_BOOT_EN] = boot_seg_en_r;
        rdata_nxt[bcp_pkg::ST_BOOT_WR] = boot_wr_allow_r;
        rdata_nxt[bcp_pkg::ST_USER_WR] = user_wr_allow_r;
        rdata_nxt[bcp_pkg::ST_CFG_WR] = cfg_wr_allow_r;
        rdata_nxt[bcp_pkg::ST_SWAP_EN] = swap_instr_en_r;
        rdata_nxt[bcp_pkg::ST_ALT_VEC] = alt_vector_en_r;
        rdata_nxt[bcp_pkg::ST_FAST_RC] = fast_rc_sel_r;
        rdata_nxt[bcp_pkg::ST_PWM_LOCK] = cfg_r.pwm_write_key_lock;
        rdata_nxt[bcp_pkg::ST_PWM_OPEN] = (key_st_r == bcp_pkg::KEY_OPEN);
        rdata_nxt[bcp_pkg::ST_PART_B] = part_b_active_r;
        rdata_nxt[bcp_pkg::ST_SEQ_A_OK] = a_ok_r;
        rdata_nxt[bcp_pkg::ST_SEQ_B_OK] = b_ok_r;
      end
      bcp_pkg::ADDR_BOOT: rdata_nxt[12:0] = boot_last_page_r;
      bcp_pkg::ADDR_CTRL: rdata_nxt = ctrl_r;
      bcp_pkg::ADDR_KEY: ;
      default: rresp_nxt = bcp_pkg::RESP_SLVERR;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= bcp_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdata_nxt;
      s_axi_rresp <= rresp_nxt;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // PWM key sequence
  // ----------------------------------------------------------------
  // One key sequence opens exactly one PWM write, so a stray write cannot reuse it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      key_st_r <= bcp_pkg::KEY_IDLE;
      pwm_wr_accept_r <= 1'b0;
      pwm_wr_reject_r <= 1'b0;
    end else begin
      pwm_wr_accept_r <= pwm_wr_req
                         && (!cfg_r.pwm_write_key_lock || key_st_r == bcp_pkg::KEY_OPEN);
      pwm_wr_reject_r <= pwm_wr_req && cfg_r.pwm_write_key_lock
                         && (key_st_r != bcp_pkg::KEY_OPEN);
      case (key_st_r)
        bcp_pkg::KEY_IDLE: begin
          if (key_wr && wdata_r[15:0] == bcp_pkg::PWM_KEY_FIRST) begin
            key_st_r <= bcp_pkg::KEY_HALF;
          end
        end
        bcp_pkg::KEY_HALF: begin
          if (key_wr) begin
            key_st_r <= (wdata_r[15:0] == bcp_pkg::PWM_KEY_SECOND) ? bcp_pkg::KEY_OPEN
                                                                    : bcp_pkg::KEY_IDLE;
          end
        end
        bcp_pkg::KEY_OPEN: begin
          if (pwm_wr_req) begin
            key_st_r <= bcp_pkg::KEY_IDLE;
          end
        end
        default: key_st_r <= bcp_pkg::KEY_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic up_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      up_r <= 1'b0;
    end else begin
      up_r <= 1'b1;
    end
  end

  // The second key word lands while the first is already remembered.
  sequence s_key_pair;
    key_st_r == bcp_pkg::KEY_HALF && key_wr && wdata_r[15:0] == bcp_pkg::PWM_KEY_SECOND;
  endsequence

  a_boot_level: assert property (up_r |-> (boot_level_r == bcp_pkg::SEC_HIGH)
    == !cfg_r.boot_seg_protect_level[1]) else $error("boot level decode wrong");
  a_boot_present: assert property (up_r
    |-> boot_seg_en_r != cfg_r.boot_seg_present_n) else $error("boot segment presence wrong");
  a_boot_write: assert property (nvm_wr.valid && up_r
    && nvm_wr.seg == bcp_pkg::SEG_BOOT
    && (!cfg_r.boot_write_guard_n || cfg_r.boot_seg_present_n)
    |=> nvm_wr_refuse_r && !nvm_wr_grant_r) else $error("guarded boot write not refused");
  a_page_limit: assert property (up_r && !cfg_r.boot_seg_present_n
    |-> (boot_last_page_r | cfg_r.boot_page_limit) == 13'h1FFF)
    else $error("boot last page not complement");
  a_user_write: assert property (nvm_wr.valid && up_r
    && nvm_wr.seg == bcp_pkg::SEG_GENERAL |=> nvm_wr_grant_r == cfg_r.user_mem_write_guard_n)
    else $error("user write check wrong");
  a_cfg_write: assert property (nvm_wr.valid && up_r
    && nvm_wr.seg == bcp_pkg::SEG_CONFIG |=> nvm_wr_grant_r == cfg_r.config_write_guard_n)
    else $error("config write check wrong");
  a_cfg_level: assert property (up_r
    && cfg_r.config_seg_protect_level[2:1] == 2'h2 |-> config_level_r == bcp_pkg::SEC_ENHANCED)
    else $error("config enhanced level wrong");
  a_swap_block: assert property (swap_instr_req
    && cfg_r.swap_instr_disable |=> !swap_instr_fire_r)
    else $error("disabled swap instruction fired");
  a_alt_vector: assert property (alt_vector_en_r |-> boot_seg_en_r
    && !cfg_r.alt_vector_table_disable && $past(ctrl_r[bcp_pkg::CTRL_ALT_SEL_BIT]))
    else $error("alternate vector table enabled illegally");
  // The reset level is part of the trigger, since the release edge itself still shows START.
  a_two_speed: assert property (aresetn && osc_state_r == bcp_pkg::OSC_START
    |=> fast_rc_sel_r == cfg_r.two_speed_startup_enable)
    else $error("start-up oscillator choice wrong");
  a_pwm_locked: assert property (pwm_wr_req && cfg_r.pwm_write_key_lock
    && key_st_r != bcp_pkg::KEY_OPEN |=> pwm_wr_reject_r && !pwm_wr_accept_r)
    else $error("locked PWM write accepted");
  a_pwm_unlock: assert property (s_key_pair |=> key_st_r == bcp_pkg::KEY_OPEN)
    else $error("key sequence did not unlock");
  a_cfg_stable: assert property (up_r
    |-> $stable(cfg_r) && $stable(seq_a_r) && $stable(seq_b_r))
    else $error("captured configuration changed");

endmodule // boot_code_protect_config

// File: test/testbench.sv
`timescale 1ns/1ns
module testbench;
  // ---------------------------------------------------------------
  // Ports of the block
  // ---------------------------------------------------------------
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  bcp_pkg::nv_cfg_t nv_cfg = '0;
  bcp_pkg::boot_seq_t seq_a = '0;
  bcp_pkg::boot_seq_t seq_b = '0;
  bcp_pkg::nvm_wr_t nvm_wr = '0;
  logic user_osc_ready = 1'h0;
  logic swap_instr_req = 1'h0;
  logic pwm_wr_req = 1'h0;
  logic dual_partition_mode = 1'h1;
  logic [11:0] s_axi_awaddr = '0;
  logic [11:0] s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_bready = 1'h1;
  logic s_axi_rready = 1'h1;
  bcp_pkg::osc_state_t osc_state_r;
  bcp_pkg::sec_t boot_level_r, general_level_r, config_level_r;
  logic fast_rc_sel_r, nvm_wr_grant_r, nvm_wr_refuse_r, swap_instr_fire_r;
  logic pwm_wr_accept_r, pwm_wr_reject_r, boot_seg_en_r, boot_wr_allow_r;
  logic user_wr_allow_r, cfg_wr_allow_r, swap_instr_en_r, alt_vector_en_r, part_b_active_r;
  logic [12:0] boot_last_page_r;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic [1:0] rs;

  boot_code_protect_config u_dut (.*);

  initial begin
    forever #5 aclk = ~aclk;
  end

  // ---------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Configuration is only captured while reset is low, so it is set up first.
  task automatic do_reset(input logic [27:0] c, input logic [47:0] s);
    nv_cfg <= c;
    {seq_a, seq_b} <= s;
    aresetn <= 1'h0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (3) @(posedge aclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
  endtask

  task automatic rdw(input logic [11:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
  endtask

  // Kind bit 0 is a memory write, bit 1 the swap instruction, bit 2 a PWM write.
  task automatic fire(input logic [2:0] k, input logic [1:0] s, input logic [1:0] exp);
    nvm_wr <= {k[0], s};
    swap_instr_req <= k[1];
    pwm_wr_req <= k[2];
    @(posedge aclk);
    nvm_wr <= '0;
    swap_instr_req <= 1'h0;
    pwm_wr_req <= 1'h0;
    @(negedge aclk);
    chk(k[0] ? {nvm_wr_grant_r, nvm_wr_refuse_r} : k[1] ? {swap_instr_fire_r, 1'h0} :
        {pwm_wr_accept_r, pwm_wr_reject_r}, exp);
    @(posedge aclk);
  endtask

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      finish_test();
    end
  end

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    do_reset({2'h2, 1'h0, 1'h1, 13'h1FFD, 2'h3, 1'h0, 1'h1, 3'h5, 4'h3},
             {12'h005, 12'hFFA, 12'h003, 12'h003});
    chk({boot_level_r, general_level_r, config_level_r}, 6'h12);
    chk({boot_seg_en_r, boot_last_page_r}, 14'h2002);
    chk({boot_wr_allow_r, user_wr_allow_r, cfg_wr_allow_r, swap_instr_en_r}, 4'hB);
    chk(part_b_active_r, 1'h0);
    chk({osc_state_r, fast_rc_sel_r}, 4'h5);
    user_osc_ready <= 1'h1;
    repeat (3) @(posedge aclk);
    chk({osc_state_r, fast_rc_sel_r}, 4'h8);
    chk(alt_vector_en_r, 1'h0);
    wr(bcp_pkg::ADDR_CTRL, 32'h0000_0100);
    repeat (2) @(posedge aclk);
    chk(alt_vector_en_r, 1'h1);
    fire(3'h1, 2'h0, 2'h2);
    fire(3'h1, 2'h1, 2'h1);
    fire(3'h1, 2'h2, 2'h2);
    fire(3'h2, 2'h0, 2'h2);
    fire(3'h4, 2'h0, 2'h1);
    wr(bcp_pkg::ADDR_KEY, 32'h0000_A5A5);
    wr(bcp_pkg::ADDR_KEY, 32'h0000_1234);
    fire(3'h4, 2'h0, 2'h1);
    wr(bcp_pkg::ADDR_KEY, 32'h0000_A5A5);
    wr(bcp_pkg::ADDR_KEY, 32'h0000_5A5A);
    rdw(bcp_pkg::ADDR_STATUS);
    chk({rd[17:16], rd[14]}, 3'h3);
    fire(3'h4, 2'h0, 2'h2);
    fire(3'h4, 2'h0, 2'h1);
    rdw(bcp_pkg::ADDR_BOOT);
    chk(rd, 32'h0000_0002);
    rdw(12'h010);
    chk({rs, rd}, {2'h2, 32'h0000_0000});
    wr(12'h010, 32'h0000_0000);
    chk(rs, bcp_pkg::RESP_SLVERR);
    // A change of the stored fields outside reset must not reach the outputs.
    nv_cfg <= '0;
    repeat (3) @(posedge aclk);
    chk({boot_level_r, general_level_r, config_level_r, boot_seg_en_r}, 7'h25);
    user_osc_ready <= 1'h0;
    do_reset({2'h0, 1'h1, 1'h1, 13'h0000, 2'h1, 1'h1, 1'h0, 3'h3, 4'h8},
             {12'h009, 12'hFF6, 12'h004, 12'hFFB});
    chk({boot_level_r, general_level_r, config_level_r}, 6'h3F);
    chk({boot_seg_en_r, boot_last_page_r, user_wr_allow_r, cfg_wr_allow_r, swap_instr_en_r},
        16'h0004);
    chk(part_b_active_r, 1'h1);
    chk({osc_state_r, fast_rc_sel_r}, 4'h8);
    fire(3'h1, 2'h0, 2'h1);
    fire(3'h2, 2'h0, 2'h0);
    fire(3'h4, 2'h0, 2'h2);
    wr(bcp_pkg::ADDR_CTRL, 32'h0000_0100);
    repeat (2) @(posedge aclk);
    chk(alt_vector_en_r, 1'h0);
    finish_test();
  end
endmodule // testbench
